// file: aspd_top.sv
// analogue speed input conditioner with its holding registers
`timescale 1ns/10ps
`default_nettype none
`include "aspd_defs.svh"
// What this block does
// - Holds input bias in mV, 0 to 1650, reset 0, applied in conditioning.
// - Low-pass filters the input; cut-off 0 to 2000 Hz, reset 10.
// - Holds a dead zone in mV, 0 to 1000, reset 50.
// - Subtracts a zero-drift correction in mV, 0 to 1000, reset 0.
// - Full-scale speed at 3.3 V, 0 to 3000 RPM, reset 100.
// - Raw sampled input voltage in mV readable at offset 0x115.
// - Conditioned voltage in mV readable at offset 0x116.
// - Resulting speed in RPM readable at offset 0x117.
module aspd_top
  import aspd_pkg::*;
#(
  parameter int unsigned SAMPLE_HZ = `ASPD_SAMPLE_HZ
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // sampled input voltage from the converter logic, same clock
  input wire logic sample_valid,
  input wire aspd_word_t sample_mv,
  // holding register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire aspd_word_t reg_addr,
  input wire aspd_word_t reg_wdata,
  output aspd_word_t reg_rdata,
  output logic reg_rvalid,
  output logic reg_err,
  // speed command out
  output aspd_word_t speed_rpm,
  output logic speed_valid
);
  localparam int unsigned COEF_INT = `ASPD_TWO_PI_Q16 / SAMPLE_HZ;
  localparam logic [15:0] COEF_PER_HZ = 16'(COEF_INT);

  // the coefficient approximation needs at least one lsb per hertz
  generate
    if (SAMPLE_HZ < 1 || COEF_INT < 1 || COEF_INT > 65535)
    begin : g_bad_rate
      $error("aspd_top: SAMPLE_HZ out of range");
    end
  endgenerate

  aspd_word_t bias_r, bias_nxt;
  aspd_word_t cutoff_r, cutoff_nxt;
  aspd_word_t dead_r, dead_nxt;
  aspd_word_t drift_r, drift_nxt;
  aspd_word_t fspeed_r, fspeed_nxt;
  aspd_word_t raw_r, raw_nxt;
  aspd_word_t cond_r, cond_nxt;
  aspd_word_t speed_r, speed_nxt;
  aspd_word_t rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic err_r, err_nxt;
  logic cond_vld_r, cond_vld_nxt;
  logic spd_vld_r, spd_vld_nxt;
  aspd_word_t filt;
  logic filt_valid;
  aspd_alpha_t alpha;
  logic [31:0] coef;
  aspd_wide_t corr;
  logic [16:0] corr_mag;
  logic cond_neg_r, cond_neg_nxt;
  logic [16:0] cond_mag_r, cond_mag_nxt;
  logic [28:0] scaled;
  logic [49:0] quot;
  logic [17:0] spd_mag;
  logic [15:0] spd_sat;

  // limit a write to the documented maximum rather than refuse it
  function automatic aspd_word_t clamp(input aspd_word_t v,
                                       input aspd_word_t lim);
    clamp = (v > lim) ? lim : v;
  endfunction

  // cut-off to q16 coefficient; zero or too high a cut-off bypasses
  always_comb
  begin
    coef = cutoff_r * COEF_PER_HZ;
    if (cutoff_r == 16'h0000 || coef >= 32'h0001_0000)
      alpha = `ASPD_ALPHA_ONE;
    else
      alpha = coef[16:0];
  end

  aspd_lpf u_lpf (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .in_valid(sample_valid),
    .x(sample_mv),
    .alpha(alpha),
    .y(filt),
    .out_valid(filt_valid)
  );

  // register writes and reads
  always_comb
  begin
    bias_nxt = bias_r;
    cutoff_nxt = cutoff_r;
    dead_nxt = dead_r;
    drift_nxt = drift_r;
    fspeed_nxt = fspeed_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = reg_rd_en;
    err_nxt = 1'b0;
    if (reg_wr_en)
    begin
      case (reg_addr)
        `ASPD_OFS_BIAS: bias_nxt = clamp(reg_wdata, `ASPD_MAX_BIAS);
        `ASPD_OFS_CUTOFF:
          cutoff_nxt = clamp(reg_wdata, `ASPD_MAX_CUTOFF);
        `ASPD_OFS_DEAD: dead_nxt = clamp(reg_wdata, `ASPD_MAX_DEAD);
        `ASPD_OFS_DRIFT:
          drift_nxt = clamp(reg_wdata, `ASPD_MAX_DRIFT);
        `ASPD_OFS_FSPEED:
          fspeed_nxt = clamp(reg_wdata, `ASPD_MAX_FSPEED);
        default: err_nxt = 1'b1;
      endcase
    end
    if (reg_rd_en)
    begin
      case (reg_addr)
        `ASPD_OFS_BIAS: rdata_nxt = bias_r;
        `ASPD_OFS_CUTOFF: rdata_nxt = cutoff_r;
        `ASPD_OFS_DEAD: rdata_nxt = dead_r;
        `ASPD_OFS_DRIFT: rdata_nxt = drift_r;
        `ASPD_OFS_FSPEED: rdata_nxt = fspeed_r;
        `ASPD_OFS_RAW: rdata_nxt = raw_r;
        `ASPD_OFS_COND: rdata_nxt = cond_r;
        `ASPD_OFS_SPEED: rdata_nxt = speed_r;
        default:
        begin
          rdata_nxt = 16'h0000;
          err_nxt = 1'b1;
        end
      endcase
    end
  end

  // drift and bias subtracted from the filtered voltage, then dead zone
  always_comb
  begin
    raw_nxt = sample_valid ? sample_mv : raw_r;
    corr = $signed({2'b00, filt}) - $signed({2'b00, drift_r})
           - $signed({2'b00, bias_r});
    corr_mag = corr[17] ? 17'(-corr) : corr[16:0];
    cond_vld_nxt = filt_valid;
    cond_neg_nxt = cond_neg_r;
    cond_mag_nxt = cond_mag_r;
    cond_nxt = cond_r;
    if (filt_valid)
    begin
      if (corr_mag <= {1'b0, dead_r})
      begin
        cond_neg_nxt = 1'b0;
        cond_mag_nxt = 17'h0_0000;
        cond_nxt = 16'h0000;
      end
      else
      begin
        cond_neg_nxt = corr[17];
        // a large input saturates to keep the reading sign-correct
        if (corr > $signed(`ASPD_COND_MAX))
          cond_nxt = 16'h7fff;
        else
          cond_nxt = corr[15:0];
        cond_mag_nxt = (corr_mag > 17'(`ASPD_COND_MAX)) ?
                       17'(`ASPD_COND_MAX) : corr_mag;
      end
    end
  end

  // speed = mag * full scale / 3300 by reciprocal, sign restored after
  always_comb
  begin
    scaled = cond_mag_r[16:0] * fspeed_r[11:0];
    quot = scaled * `ASPD_RECIP_Q32;
    spd_mag = quot[49:32];
    spd_sat = (spd_mag > 18'h0_7fff) ? 16'h7fff : spd_mag[15:0];
    spd_vld_nxt = cond_vld_r;
    speed_nxt = speed_r;
    if (cond_vld_r)
      speed_nxt = cond_neg_r ? 16'(-spd_sat) : spd_sat;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bias_r <= `ASPD_RST_BIAS;
      cutoff_r <= `ASPD_RST_CUTOFF;
      dead_r <= `ASPD_RST_DEAD;
      drift_r <= `ASPD_RST_DRIFT;
      fspeed_r <= `ASPD_RST_FSPEED;
      raw_r <= 16'h0000;
      cond_r <= 16'h0000;
      speed_r <= 16'h0000;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
      err_r <= 1'b0;
      cond_vld_r <= 1'b0;
      spd_vld_r <= 1'b0;
      cond_neg_r <= 1'b0;
      cond_mag_r <= 17'h0_0000;
    end
    else if (ce)
    begin
      bias_r <= bias_nxt;
      cutoff_r <= cutoff_nxt;
      dead_r <= dead_nxt;
      drift_r <= drift_nxt;
      fspeed_r <= fspeed_nxt;
      raw_r <= raw_nxt;
      cond_r <= cond_nxt;
      speed_r <= speed_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      err_r <= err_nxt;
      cond_vld_r <= cond_vld_nxt;
      spd_vld_r <= spd_vld_nxt;
      cond_neg_r <= cond_neg_nxt;
      cond_mag_r <= cond_mag_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign reg_err = err_r;
  assign speed_rpm = speed_r;
  assign speed_valid = spd_vld_r;
endmodule
`default_nettype wire

// file: aspd_defs.svh
// register offsets, reset values, limits and scaling constants
`ifndef ASPD_DEFS_SVH
`define ASPD_DEFS_SVH
`define ASPD_OFS_BIAS 16'h0110
`define ASPD_OFS_CUTOFF 16'h0111
`define ASPD_OFS_DEAD 16'h0112
`define ASPD_OFS_DRIFT 16'h0113
`define ASPD_OFS_FSPEED 16'h0114
`define ASPD_OFS_RAW 16'h0115
`define ASPD_OFS_COND 16'h0116
`define ASPD_OFS_SPEED 16'h0117
`define ASPD_RST_BIAS 16'h0000
`define ASPD_RST_CUTOFF 16'h000a
`define ASPD_RST_DEAD 16'h0032
`define ASPD_RST_DRIFT 16'h0000
`define ASPD_RST_FSPEED 16'h0064
`define ASPD_MAX_BIAS 16'h0672
`define ASPD_MAX_CUTOFF 16'h07d0
`define ASPD_MAX_DEAD 16'h03e8
`define ASPD_MAX_DRIFT 16'h03e8
`define ASPD_MAX_FSPEED 16'h0bb8
`define ASPD_FULL_SCALE_MV 3300
`define ASPD_RECIP_Q32 21'h13_dc02
`define ASPD_TWO_PI_Q16 411775
`define ASPD_SAMPLE_HZ 10000
`define ASPD_ALPHA_ONE 17'h1_0000
`define ASPD_COND_MAX 18'h0_7fff
`endif

// file: aspd_pkg.sv
// shared types of the analogue speed input conditioner
`default_nettype none
package aspd_pkg;
  typedef logic [15:0] aspd_word_t;
  typedef logic signed [17:0] aspd_wide_t;
  typedef logic [16:0] aspd_alpha_t;
endpackage
`default_nettype wire

// file: aspd_lpf.sv
// first-order low-pass filter on the sampled input voltage
`timescale 1ns/10ps
`default_nettype none
`include "aspd_defs.svh"
module aspd_lpf
  import aspd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // sample in
  input wire logic in_valid,
  input wire aspd_word_t x,
  input wire aspd_alpha_t alpha,
  // filtered out
  output aspd_word_t y,
  output logic out_valid
);
  logic [31:0] acc_r;
  logic [31:0] acc_nxt;
  logic valid_r;
  logic valid_nxt;
  logic signed [32:0] diff;
  logic signed [50:0] prod;

  // q16 accumulator; alpha of one means the filter is bypassed
  always_comb
  begin
    diff = $signed({1'b0, x, 16'h0000}) - $signed({1'b0, acc_r});
    prod = diff * $signed({1'b0, alpha});
    acc_nxt = acc_r;
    valid_nxt = 1'b0;
    if (in_valid)
    begin
      valid_nxt = 1'b1;
      if (alpha >= `ASPD_ALPHA_ONE)
        acc_nxt = {x, 16'h0000};
      else
        acc_nxt = acc_r + prod[47:16];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_r <= 32'h0000_0000;
      valid_r <= 1'b0;
    end
    else if (ce)
    begin
      acc_r <= acc_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign y = acc_r[31:16];
  assign out_valid = valid_r;
endmodule
`default_nettype wire

// file: aspd_chk.sv
// port assertions for the conditioner
`timescale 1ns/10ps
`default_nettype none
module aspd_chk
  import aspd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // requests
  input wire logic sample_valid,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire aspd_word_t reg_addr,
  // answers
  input wire aspd_word_t reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_err,
  input wire logic speed_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic rd;
  logic wr;
  logic bad;
  logic ro;
  assign rd = reg_rd_en && ce;
  assign wr = reg_wr_en && ce;
  assign bad = reg_addr < 16'h0110 || reg_addr > 16'h0117;
  assign ro = reg_addr >= 16'h0115 && !bad;
  // three running cycles carry a sample to the speed output
  sequence s_samp;
    sample_valid && ce ##1 ce [*2];
  endsequence
  a_read_answer: assert property (rd |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property ($rose(reg_rvalid) |-> $past(reg_rd_en))
    else $error("answer without read");
  a_rdata_hold: assert property (!rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_unmap_read: assert property (rd && bad |=> reg_err && reg_rdata == 0)
    else $error("unmapped read");
  a_ro_write: assert property (wr && ro |=> reg_err)
    else $error("read-only write accepted");
  a_rw_ok: assert property (wr && !bad && !ro && !reg_rd_en |=> !reg_err)
    else $error("config write refused");
  a_speed_lat: assert property (s_samp |=> speed_valid)
    else $error("speed late");
  a_speed_cause: assert property ($rose(speed_valid) |-> $past(sample_valid, 3))
    else $error("speed without sample");
endmodule
`default_nettype wire

// file: aspd_src.sv
// analogue source model
`timescale 1ns/10ps
`default_nettype none
module aspd_src
  import aspd_pkg::*;
(
  // clock
  input wire logic clk,
  // samples
  output logic sample_valid,
  output aspd_word_t sample_mv
);
  initial
  begin
    sample_valid = 1'b0;
    sample_mv = 16'h0000;
  end
  // value scrambled between samples so nothing leans on a stale one
  task automatic send(input aspd_word_t mv);
    @(negedge clk);
    sample_valid = 1'b1;
    sample_mv = mv;
    @(negedge clk);
    sample_valid = 1'b0;
    sample_mv = ~mv;
  endtask
endmodule
`default_nettype wire

// file: aspd_tb.sv
// self-checking bench for the conditioner
`timescale 1ns/10ps
`default_nettype none
`include "aspd_defs.svh"
module tb
  import aspd_pkg::*;
;
  logic clk, reset_n, ce, wr, rd, rvalid, err, svalid, sv, e;
  aspd_word_t addr, wdata, rdata, speed, smv, r;
  int n_fail, check_count;
  aspd_word_t rst[5] = '{`ASPD_RST_BIAS, `ASPD_RST_CUTOFF,
    `ASPD_RST_DEAD, `ASPD_RST_DRIFT, `ASPD_RST_FSPEED};
  aspd_word_t mx[5] = '{`ASPD_MAX_BIAS, `ASPD_MAX_CUTOFF,
    `ASPD_MAX_DEAD, `ASPD_MAX_DRIFT, `ASPD_MAX_FSPEED};
  int mvs[5] = '{3300, 340, 350, 351, 100};
  int cs[5] = '{3000, 0, 0, 51, -200};
  aspd_top aspd_top_inst (.clk(clk), .reset_n(reset_n), .ce(ce),
    .sample_valid(sv), .sample_mv(smv), .reg_wr_en(wr), .reg_rd_en(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .reg_err(err), .speed_rpm(speed),
    .speed_valid(svalid));
  aspd_src aspd_src_inst (.clk(clk), .sample_valid(sv), .sample_mv(smv));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string n, input aspd_word_t x, aspd_word_t g);
    check_count++;
    if (g !== x)
    begin
      n_fail++;
      $display("Error %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic acc(input logic w, input aspd_word_t a, aspd_word_t d);
    @(negedge clk);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    r = rdata;
    e = err;
    if (!w)
      chk("rvalid", 16'h0001, {15'h0000, rvalid});
  endtask
  task automatic rdc(input aspd_word_t a, input aspd_word_t x);
    acc(1'b0, a, 16'h0000);
    chk($sformatf("reg %h", a), x, r);
  endtask
  // speed scaled by the reciprocal of full scale, sign kept
  function automatic aspd_word_t spd(input int c, input int fs);
    longint m;
    m = c < 0 ? -c : c;
    m = ((m > 32767 ? 32767 : m) * fs * `ASPD_RECIP_Q32) >> 32;
    m = m > 32767 ? 32767 : m;
    return aspd_word_t'(c < 0 ? -m : m);
  endfunction
  task automatic smp(input int mv, input int c);
    int i;
    aspd_src_inst.send(aspd_word_t'(mv));
    i = 0;
    while (svalid !== 1'b1 && i < 8)
    begin
      @(negedge clk);
      i++;
    end
    chk("svalid", 16'h0001, {15'h0000, svalid});
    chk("speed", spd(c, 3000), speed);
    rdc(16'h0115, aspd_word_t'(mv));
    rdc(16'h0116, aspd_word_t'(c));
    rdc(16'h0117, spd(c, 3000));
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    {ce, wr, rd, addr, wdata, n_fail, check_count} = '0;
    ce = 1'b1;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    for (int k = 0; k < 5; k++)
      rdc(aspd_word_t'(16'h0110 + k), rst[k]);
    $display("test reset values done");
    for (int k = 0; k < 5; k++)
    begin
      acc(1'b1, aspd_word_t'(16'h0110 + k), mx[k] + 16'h0001);
      chk("werr", 16'h0000, {15'h0000, e});
      rdc(aspd_word_t'(16'h0110 + k), mx[k]);
    end
    $display("test clamp done");
    acc(1'b1, 16'h0117, 16'h1234);
    chk("ro err", 16'h0001, {15'h0000, e});
    rdc(16'h0118, 16'h0000);
    chk("rd err", 16'h0001, {15'h0000, e});
    $display("test refusals done");
    acc(1'b1, 16'h0111, 16'h0000);
    acc(1'b1, 16'h0110, 16'h00c8);
    acc(1'b1, 16'h0113, 16'h0064);
    acc(1'b1, 16'h0112, 16'h0032);
    for (int k = 0; k < 5; k++)
      smp(mvs[k], cs[k]);
    $display("test conditioning done");
    @(negedge clk) reset_n = 1'b0;
    @(negedge clk) reset_n = 1'b1;
    acc(1'b1, 16'h0112, 16'h0000);
    aspd_src_inst.send(16'h0ce4);
    repeat (3) @(negedge clk);
    acc(1'b0, 16'h0116, 16'h0000);
    chk("filter", 16'h0001, {15'h0000, r > 0 && r < 16'd100});
    $display("test filter done");
    // a write made while the clock enable is low must not land
    ce = 1'b0;
    acc(1'b1, 16'h0112, 16'h0064);
    ce = 1'b1;
    rdc(16'h0112, 16'h0000);
    $display("test freeze done");
    end_of_test();
  end
endmodule
bind aspd_top aspd_chk aspd_chk_inst (.clk(clk), .reset_n(reset_n),
  .ce(ce), .sample_valid(sample_valid), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .reg_err(reg_err), .speed_valid(speed_valid));
`default_nettype wire
